// ==== shared/sec_lock_pkg.sv ====
package sec_lock_pkg;
	// ----------------------------------------
	// security command opcodes
	// ----------------------------------------
	localparam logic [7:0] OP_SET_PW = 8'hf1;
	localparam logic [7:0] OP_UNLOCK = 8'hf2;
	localparam logic [7:0] OP_ERASE_PREP = 8'hf3;
	localparam logic [7:0] OP_ERASE_UNIT = 8'hf4;
	localparam logic [7:0] OP_FREEZE = 8'hf5;
	localparam logic [7:0] OP_DISABLE_PW = 8'hf6;
	// ----------------------------------------
	// media access and config opcodes gated in locked mode
	// ----------------------------------------
	localparam logic [7:0] OP_RD_SEC = 8'h20;
	localparam logic [7:0] OP_RD_SEC_EXT = 8'h24;
	localparam logic [7:0] OP_RD_DMA_EXT = 8'h25;
	localparam logic [7:0] OP_RD_MUL_EXT = 8'h29;
	localparam logic [7:0] OP_WR_SEC = 8'h30;
	localparam logic [7:0] OP_WR_SEC_EXT = 8'h34;
	localparam logic [7:0] OP_WR_DMA_EXT = 8'h35;
	localparam logic [7:0] OP_WR_MUL_EXT = 8'h39;
	localparam logic [7:0] OP_SET_MAX_EXT = 8'h37;
	localparam logic [7:0] OP_VERIFY = 8'h40;
	localparam logic [7:0] OP_VERIFY_EXT = 8'h42;
	localparam logic [7:0] OP_FORMAT_TRK = 8'h50;
	localparam logic [7:0] OP_WR_VERIFY = 8'h3c;
	localparam logic [7:0] OP_RD_LONG = 8'h22;
	localparam logic [7:0] OP_WR_LONG = 8'h32;
	localparam logic [7:0] OP_RD_MUL = 8'hc4;
	localparam logic [7:0] OP_WR_MUL = 8'hc5;
	localparam logic [7:0] OP_RD_DMA = 8'hc8;
	localparam logic [7:0] OP_WR_DMA = 8'hca;
	localparam logic [7:0] OP_FLUSH = 8'he7;
	localparam logic [7:0] OP_FLUSH_EXT = 8'hea;
	localparam logic [7:0] OP_FORMAT_UNIT = 8'hf7;
	localparam logic [7:0] OP_SET_MAX = 8'hf9;
	localparam logic [7:0] OP_DEV_CFG = 8'hb1;
	// device configuration subcommands (feature field)
	localparam logic [7:0] DCO_RESTORE = 8'hc0;
	localparam logic [7:0] DCO_SET = 8'hc3;
	// set max subcommand meaning "address"
	localparam logic [7:0] SETMAX_ADDR = 8'h00;
	// ----------------------------------------
	// revision code, attempt limit, identify bits
	// ----------------------------------------
	localparam logic [15:0] REV_DEFAULT = 16'hfffe;
	localparam logic [15:0] REV_RSVD_LO = 16'h0000;
	localparam logic [15:0] REV_RSVD_HI = 16'hffff;
	localparam logic [2:0] ATTEMPT_LIMIT = 3'h5;
	localparam int EXPIRED_BIT = 4;
	localparam int REV_WORD = 92;
	localparam int STATUS_WORD = 128;
	typedef enum logic [1:0] {MODE_UNLOCKED, MODE_LOCKED, MODE_FROZEN} mode_e;
endpackage

// ==== rtl/ata_security_lock_control.sv ====
`timescale 1ns/1ps
// Operation
// - decode opcodes F1h through F6h
// - user password set: power on locked (nrst here clears the user password, so power on is always unlocked)
// - only unlock or erase unit unlock
// - no password: power on unlocked
// - freeze blocks password commands until power off
// - locked mode command accept list
// - high level: master unlocks via unlock
// - maximum level: master only via erase
// - master password never enables lock
// - user password locks at next reset
// - master revision code, default FFFEh
// - one shared mismatch counter
// - five mismatches set expired, abort unlock
// - resets clear counter and expired flag
module ata_security_lock_control
	import sec_lock_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	input wire logic clk_en,
	// hard reset from the task file, same clock
	input wire logic hard_reset,
	// command strobe and task file
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_opcode,
	input wire logic [7:0] cmd_feature,
	// decoded data sector, valid with cmd_valid
	input wire logic sect_pw_master,
	input wire logic sect_level_max,
	input wire logic [15:0] sect_rev_code,
	input wire logic pw_match_user,
	input wire logic pw_match_master,
	// answer
	output logic resp_valid,
	output logic resp_abort,
	output logic data_in_req,
	output logic erase_start,
	// state shown in identify data
	output logic [1:0] sec_mode,
	output logic user_pw_set,
	output logic level_max,
	output logic [15:0] master_rev_code,
	output logic unlock_attempts_expired,
	output logic [2:0] mismatch_count
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	mode_e mode_ff, nxt_mode;
	logic user_set_ff, nxt_user_set;
	logic lvl_max_ff, nxt_lvl_max;
	logic [15:0] rev_ff, nxt_rev;
	logic [2:0] cnt_ff, nxt_cnt;
	logic expired_ff, nxt_expired;
	logic prep_ff, nxt_prep;
	logic rv_ff, nxt_rv;
	logic ab_ff, nxt_ab;
	logic dreq_ff, nxt_dreq;
	logic erase_ff, nxt_erase;
	logic media_cmd;
	logic pw_ok;

	// ----------------------------------------
	// command gating
	// ----------------------------------------
	always_comb begin
		unique case (cmd_opcode)
			OP_RD_SEC, OP_RD_SEC_EXT, OP_RD_DMA, OP_RD_DMA_EXT, OP_RD_MUL, OP_RD_MUL_EXT, OP_RD_LONG,
			OP_WR_SEC, OP_WR_SEC_EXT, OP_WR_DMA, OP_WR_DMA_EXT, OP_WR_MUL, OP_WR_MUL_EXT, OP_WR_LONG,
			OP_VERIFY, OP_VERIFY_EXT, OP_WR_VERIFY, OP_FORMAT_TRK, OP_FORMAT_UNIT,
			OP_FLUSH, OP_FLUSH_EXT, OP_SET_MAX_EXT: media_cmd = 1'b1;
			OP_SET_MAX: media_cmd = (cmd_feature == SETMAX_ADDR);
			OP_DEV_CFG: media_cmd = (cmd_feature == DCO_RESTORE) || (cmd_feature == DCO_SET);
			default: media_cmd = 1'b0;
		endcase
	end

	// mismatch counts whichever password type the sector names
	always_comb begin
		pw_ok = sect_pw_master ? pw_match_master : pw_match_user;
	end

	always_comb begin
		nxt_mode = mode_ff;
		nxt_user_set = user_set_ff;
		nxt_lvl_max = lvl_max_ff;
		nxt_rev = rev_ff;
		nxt_cnt = cnt_ff;
		nxt_expired = expired_ff;
		nxt_prep = prep_ff;
		nxt_rv = 1'b0;
		nxt_ab = ab_ff;
		nxt_dreq = 1'b0;
		nxt_erase = 1'b0;
		if (hard_reset) begin
			// hard reset relocks if a user password stands; frozen is left only by power off
			if (mode_ff != MODE_FROZEN)
				nxt_mode = user_set_ff ? MODE_LOCKED : MODE_UNLOCKED;
			nxt_cnt = 3'h0;
			nxt_expired = 1'b0;
			nxt_prep = 1'b0;
			nxt_ab = 1'b0;
		end else if (cmd_valid) begin
			nxt_rv = 1'b1;
			nxt_ab = 1'b0;
			nxt_prep = 1'b0;
			unique case (cmd_opcode)
				OP_SET_PW: begin
					nxt_dreq = 1'b1;
					if (mode_ff != MODE_UNLOCKED)
						nxt_ab = 1'b1;
					else if (sect_pw_master) begin
						// master alone never enables the lock
						if (sect_rev_code != REV_RSVD_LO && sect_rev_code != REV_RSVD_HI)
							nxt_rev = sect_rev_code;
					end else begin
						nxt_user_set = 1'b1;
						nxt_lvl_max = sect_level_max;
					end
				end
				OP_UNLOCK: begin
					nxt_dreq = 1'b1;
					if (mode_ff == MODE_FROZEN || expired_ff)
						nxt_ab = 1'b1;
					else if (pw_ok && !(sect_pw_master && lvl_max_ff)) begin
						if (mode_ff == MODE_LOCKED)
							nxt_mode = MODE_UNLOCKED;
					end else begin
						nxt_ab = 1'b1;
						if (!pw_ok) begin
							nxt_cnt = cnt_ff + 3'h1;
							if (cnt_ff + 3'h1 >= ATTEMPT_LIMIT)
								nxt_expired = 1'b1;
						end
					end
				end
				OP_ERASE_PREP: begin
					nxt_prep = 1'b1;
				end
				OP_ERASE_UNIT: begin
					nxt_dreq = 1'b1;
					if (mode_ff == MODE_FROZEN || expired_ff || !prep_ff)
						nxt_ab = 1'b1;
					else if (pw_ok) begin
						// erase clears the user password and unlocks
						nxt_erase = 1'b1;
						nxt_mode = MODE_UNLOCKED;
						nxt_user_set = 1'b0;
						nxt_lvl_max = 1'b0;
					end else begin
						nxt_ab = 1'b1;
						nxt_cnt = cnt_ff + 3'h1;
						if (cnt_ff + 3'h1 >= ATTEMPT_LIMIT)
							nxt_expired = 1'b1;
					end
				end
				OP_FREEZE: begin
					if (mode_ff == MODE_LOCKED)
						nxt_ab = 1'b1;
					else
						nxt_mode = MODE_FROZEN;
				end
				OP_DISABLE_PW: begin
					nxt_dreq = 1'b1;
					if (mode_ff != MODE_UNLOCKED || !pw_ok)
						nxt_ab = 1'b1;
					else begin
						nxt_user_set = 1'b0;
						nxt_lvl_max = 1'b0;
					end
				end
				default: begin
					if (mode_ff == MODE_LOCKED && media_cmd)
						nxt_ab = 1'b1;
				end
			endcase
			// saturate at the limit; counter never wraps
			if (cnt_ff >= ATTEMPT_LIMIT)
				nxt_cnt = ATTEMPT_LIMIT;
		end
	end

	// power on: locked only with a user password (kept in retained state, reset to none here)
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mode_ff <= MODE_UNLOCKED;
			user_set_ff <= 1'b0;
			lvl_max_ff <= 1'b0;
			rev_ff <= REV_DEFAULT;
			cnt_ff <= 3'h0;
			expired_ff <= 1'b0;
			prep_ff <= 1'b0;
			rv_ff <= 1'b0;
			ab_ff <= 1'b0;
			dreq_ff <= 1'b0;
			erase_ff <= 1'b0;
		end else if (clk_en) begin
			mode_ff <= nxt_mode;
			user_set_ff <= nxt_user_set;
			lvl_max_ff <= nxt_lvl_max;
			rev_ff <= nxt_rev;
			cnt_ff <= nxt_cnt;
			expired_ff <= nxt_expired;
			prep_ff <= nxt_prep;
			rv_ff <= nxt_rv;
			ab_ff <= nxt_ab;
			dreq_ff <= nxt_dreq;
			erase_ff <= nxt_erase;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign resp_valid = rv_ff;
	assign resp_abort = ab_ff;
	assign data_in_req = dreq_ff;
	assign erase_start = erase_ff;
	assign sec_mode = mode_ff;
	assign user_pw_set = user_set_ff;
	assign level_max = lvl_max_ff;
	assign master_rev_code = rev_ff;
	assign unlock_attempts_expired = expired_ff;
	assign mismatch_count = cnt_ff;
endmodule

// ==== verification/sec_lock_props.sv ====
`timescale 1ns/1ps
module sec_lock_props
	import sec_lock_pkg::*;
(
	// watched ports
	input wire logic clk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic hard_reset,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_opcode,
	input wire logic resp_valid,
	input wire logic resp_abort,
	input wire logic data_in_req,
	input wire logic erase_start,
	input wire logic [1:0] sec_mode,
	input wire logic unlock_attempts_expired,
	input wire logic [2:0] mismatch_count
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	logic tk;
	assign tk = cmd_valid && clk_en && !hard_reset;
	property p_ans; tk |=> resp_valid; endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_only; resp_valid |-> $past(tk); endproperty
	a_only: assert property (p_only) else $error("stray answer");
	property p_frz; tk && sec_mode == MODE_FROZEN && cmd_opcode inside {8'hf1, 8'hf2, 8'hf4, 8'hf6} |=> resp_abort; endproperty
	a_frz: assert property (p_frz) else $error("frozen accepted");
	property p_stay; sec_mode == MODE_FROZEN && clk_en |=> sec_mode == MODE_FROZEN; endproperty
	a_stay: assert property (p_stay) else $error("left frozen");
	property p_lck; tk && sec_mode == MODE_LOCKED && cmd_opcode inside {8'hf1, 8'hf6, 8'hf5, 8'h20, 8'h30, 8'he7}
		|=> resp_abort; endproperty
	a_lck: assert property (p_lck) else $error("locked accepted");
	property p_exp; tk && unlock_attempts_expired && cmd_opcode inside {8'hf2, 8'hf4} |=> resp_abort; endproperty
	a_exp: assert property (p_exp) else $error("expired accepted");
	property p_clr; hard_reset && clk_en |=> mismatch_count == 3'h0 && !unlock_attempts_expired; endproperty
	a_clr: assert property (p_clr) else $error("count kept");
	property p_lv; (sec_mode == MODE_LOCKED && !hard_reset) ##1 sec_mode == MODE_UNLOCKED
		|-> resp_valid && !resp_abort && $past(cmd_opcode) inside {8'hf2, 8'hf4}; endproperty
	a_lv: assert property (p_lv) else $error("bad unlock");
	property p_dat; tk && cmd_opcode inside {8'hf1, 8'hf2, 8'hf4, 8'hf6} |=> data_in_req; endproperty
	a_dat: assert property (p_dat) else $error("no sector");
	property p_ers; erase_start |-> !resp_abort && $past(cmd_opcode) == OP_ERASE_UNIT; endproperty
	a_ers: assert property (p_ers) else $error("bad erase");
endmodule
bind ata_security_lock_control sec_lock_props sec_lock_props_i (
	.clk(clk), .nrst(nrst), .clk_en(clk_en), .hard_reset(hard_reset), .cmd_valid(cmd_valid),
	.cmd_opcode(cmd_opcode), .resp_valid(resp_valid), .resp_abort(resp_abort), .data_in_req(data_in_req),
	.erase_start(erase_start), .sec_mode(sec_mode), .unlock_attempts_expired(unlock_attempts_expired),
	.mismatch_count(mismatch_count)
);

// ==== verification/sec_host.sv ====
`timescale 1ns/1ps
module sec_host
	import sec_lock_pkg::*;
(
	// clock and answer
	input wire logic clk,
	input wire logic resp_valid,
	input wire logic resp_abort,
	// command and sector
	output logic cmd_valid,
	output logic [7:0] cmd_opcode,
	output logic [7:0] cmd_feature,
	output logic sect_pw_master,
	output logic sect_level_max,
	output logic [15:0] sect_rev_code,
	output logic pw_match_user,
	output logic pw_match_master
);
	initial {cmd_valid, cmd_opcode, cmd_feature, sect_pw_master, sect_level_max, sect_rev_code} = '0;
	initial {pw_match_user, pw_match_master} = '0;
	// f = {master, level max, user match, master match}
	task issue(input logic [7:0] op, input logic [3:0] f, output logic [1:0] r, input logic [7:0] feat = 8'h00,
		input logic [15:0] rev = 16'h1234);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_opcode <= op;
		cmd_feature <= feat;
		{sect_pw_master, sect_level_max, pw_match_user, pw_match_master} <= f;
		sect_rev_code <= rev;
		@(posedge clk);
		cmd_valid <= 1'b0;
		// idle bus shows garbage, not the last code
		cmd_opcode <= ~op;
		cmd_feature <= 8'hff;
		#1 r = {resp_valid, resp_abort};
	endtask
endmodule

// ==== verification/tb_ata_security_lock_control.sv ====
`timescale 1ns/1ps
module tb_ata_security_lock_control
	import sec_lock_pkg::*;
;
	logic clk, nrst, clk_en, hard_reset, cmd_valid, sect_pw_master, sect_level_max, pw_match_user, pw_match_master;
	logic resp_valid, resp_abort, data_in_req, erase_start, user_pw_set, level_max, unlock_attempts_expired;
	logic [7:0] cmd_opcode, cmd_feature;
	logic [15:0] sect_rev_code, master_rev_code;
	logic [1:0] sec_mode, r;
	logic [2:0] mismatch_count;
	int num_errors = 0;
	int tests_run = 0;
	logic [7:0] lk [9] = '{8'h20, 8'h30, 8'h40, 8'h50, 8'he7, 8'hf9, 8'hf1, 8'hf6, 8'hf5};
	logic [7:0] fz [4] = '{8'hf1, 8'hf2, 8'hf4, 8'hf6};
	ata_security_lock_control ata_security_lock_control_i (
		.clk(clk), .nrst(nrst), .clk_en(clk_en), .hard_reset(hard_reset),
		.cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .cmd_feature(cmd_feature),
		.sect_pw_master(sect_pw_master), .sect_level_max(sect_level_max), .sect_rev_code(sect_rev_code),
		.pw_match_user(pw_match_user), .pw_match_master(pw_match_master),
		.resp_valid(resp_valid), .resp_abort(resp_abort), .data_in_req(data_in_req), .erase_start(erase_start),
		.sec_mode(sec_mode), .user_pw_set(user_pw_set), .level_max(level_max), .master_rev_code(master_rev_code),
		.unlock_attempts_expired(unlock_attempts_expired), .mismatch_count(mismatch_count)
	);
	sec_host sec_host_i (
		.clk(clk), .resp_valid(resp_valid), .resp_abort(resp_abort),
		.cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .cmd_feature(cmd_feature),
		.sect_pw_master(sect_pw_master), .sect_level_max(sect_level_max), .sect_rev_code(sect_rev_code),
		.pw_match_user(pw_match_user), .pw_match_master(pw_match_master)
	);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task chk(input logic c, input string m);
		tests_run++;
		if (c !== 1'b1) begin
			num_errors++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask
	task cmd(input logic [7:0] op, input logic [3:0] f, input logic ab);
		sec_host_i.issue(op, f, r);
		chk(r === {1'b1, ab}, $sformatf("op %h", op));
	endtask
	task hrst;
		@(posedge clk);
		hard_reset <= 1'b1;
		@(posedge clk);
		hard_reset <= 1'b0;
		#1;
	endtask
	task t_power;
		chk(sec_mode === 2'h0 && master_rev_code === 16'hfffe && mismatch_count === 3'h0, "pwr");
		cmd(OP_RD_SEC, 4'h0, 1'b0);
		// clock enable low: command must be ignored entirely
		@(posedge clk);
		clk_en <= 1'b0;
		sec_host_i.issue(OP_FREEZE, 4'h0, r);
		chk(r === 2'b00 && sec_mode === 2'h0, "clk_en");
		@(posedge clk);
		clk_en <= 1'b1;
	endtask
	task t_master;
		cmd(OP_SET_PW, 4'b1000, 1'b0);
		chk(master_rev_code === 16'h1234 && user_pw_set === 1'b0 && data_in_req === 1'b1, "rev");
		sec_host_i.issue(OP_SET_PW, 4'b1000, r, 8'h00, 16'hffff);
		chk(r === 2'b10 && master_rev_code === 16'h1234, "rsvd rev");
		hrst;
		chk(sec_mode === 2'h0, "master lock");
	endtask
	task t_locked;
		cmd(OP_SET_PW, 4'b0000, 1'b0);
		hrst;
		chk(sec_mode === 2'h1, "no lock");
		foreach (lk[i]) cmd(lk[i], 4'h0, 1'b1);
		sec_host_i.issue(OP_DEV_CFG, 4'h0, r, DCO_RESTORE);
		chk(r === 2'b11, "cfg restore");
		sec_host_i.issue(OP_SET_MAX, 4'h0, r, 8'h01);
		chk(r === 2'b10, "set max sub");
		cmd(8'hec, 4'h0, 1'b0);
		cmd(OP_ERASE_PREP, 4'h0, 1'b0);
		cmd(OP_UNLOCK, 4'b1001, 1'b0);
		chk(sec_mode === 2'h0, "unlock");
	endtask
	task t_max;
		cmd(OP_DISABLE_PW, 4'b0000, 1'b1);
		cmd(OP_DISABLE_PW, 4'b0010, 1'b0);
		chk(user_pw_set === 1'b0, "disable");
		cmd(OP_SET_PW, 4'b0100, 1'b0);
		chk(level_max === 1'b1 && user_pw_set === 1'b1, "lvl");
		hrst;
		cmd(OP_UNLOCK, 4'b1001, 1'b1);
		cmd(OP_ERASE_UNIT, 4'b1001, 1'b1);
		cmd(OP_ERASE_PREP, 4'h0, 1'b0);
		cmd(OP_ERASE_UNIT, 4'b1001, 1'b0);
		chk(erase_start === 1'b1 && sec_mode === 2'h0 && level_max === 1'b0 && user_pw_set === 1'b0, "erase");
	endtask
	task t_unlock_attempts_expired;
		hrst;
		for (int i = 0; i < 5; i++) begin
			chk(unlock_attempts_expired === 1'b0, "early");
			cmd(OP_UNLOCK, {i[0], 3'b000}, 1'b1);
		end
		chk(mismatch_count === 3'h5 && unlock_attempts_expired === 1'b1, "unlock_attempts_expired");
		cmd(OP_UNLOCK, 4'b0010, 1'b1);
		cmd(OP_ERASE_PREP, 4'h0, 1'b0);
		cmd(OP_ERASE_UNIT, 4'b1001, 1'b1);
		hrst;
		chk(mismatch_count === 3'h0 && unlock_attempts_expired === 1'b0, "clear");
		cmd(OP_UNLOCK, 4'b0010, 1'b0);
	endtask
	task t_freeze;
		cmd(OP_FREEZE, 4'h0, 1'b0);
		chk(sec_mode === 2'h2, "frz");
		foreach (fz[i]) cmd(fz[i], 4'b0011, 1'b1);
		cmd(OP_RD_SEC, 4'h0, 1'b0);
		hrst;
		chk(sec_mode === 2'h2, "frz kept");
	endtask
	task close_out;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// watchdog: the whole run needs under 200 cycles
	initial begin
		#100000;
		num_errors++;
		close_out;
	end
	initial begin
		{nrst, hard_reset} = 2'b00;
		clk_en = 1'b1;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		#1;
		t_power;
		t_master;
		t_locked;
		t_max;
		t_unlock_attempts_expired;
		t_freeze;
		close_out;
	end
endmodule
